// >>> rtl/ripsel_pkg.sv
// package: register map, field layout and source encoding of the input pin select
package ripsel_pkg;

  // ==========================================================
  // sizes
  localparam int SEL_W      = 7;
  localparam int NUM_PINS   = 128;
  localparam int NUM_INPUTS = 6;
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 4;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ENC2_SEL    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CAPT_SEL    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_SYNC_SEL    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LOCK_CTRL   = 4'hC;

  // ==========================================================
  // field positions and reset values
  localparam int HI_FIELD_LSB = 8;
  localparam int LO_FIELD_LSB = 0;
  localparam int LOCK_BIT     = 0;
  localparam logic [SEL_W-1:0] SEL_RESET   = 7'h00;
  localparam logic [REG_W-1:0] REG_RESET   = 16'h0000;
  localparam logic [REG_W-1:0] FIELD_MASK  = 16'h7F7F;

  // unlock keys, written back to back to the lock register
  localparam logic [REG_W-1:0] UNLOCK_KEY1 = 16'h0046;
  localparam logic [REG_W-1:0] UNLOCK_KEY2 = 16'h0057;
  localparam logic [REG_W-1:0] LOCK_KEY    = 16'h0001;

  // ==========================================================
  // selector encoding
  localparam logic [SEL_W-1:0] SRC_TIE_LOW   = 7'h00;
  localparam logic [SEL_W-1:0] SRC_CMP_FIRST = 7'h01;
  localparam logic [SEL_W-1:0] SRC_CMP_LAST  = 7'h03;
  localparam logic [SEL_W-1:0] SRC_ENC_FIRST = 7'h08;
  localparam logic [SEL_W-1:0] SRC_ENC_LAST  = 7'h0B;
  localparam logic [SEL_W-1:0] SRC_PIN_FIRST = 7'h10;

  // pin class: 1 = input or output capable, 0 = input only
  localparam logic [NUM_PINS-1:0] PIN_IO_CLASS =
    128'hFFFF_FFFF_FFFF_FFFF_0000_0000_0000_0000;
  // pins present in the selectable range (reserved holes cleared)
  localparam logic [NUM_PINS-1:0] PIN_PRESENT =
    128'hFFFF_FFFF_FFFF_FFFF_701E_FFFF_C0FF_0000;

  // ==========================================================
  // peripheral input indices
  localparam int IN_ENC2_INDEX = 0;
  localparam int IN_ENC2_HOME  = 1;
  localparam int IN_CAPT15     = 2;
  localparam int IN_CAPT16     = 3;
  localparam int IN_SYNC2      = 4;
  localparam int IN_SPARE      = 5;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [2:0] comparator_output;
    logic       encoder1_index_virtual;
    logic       encoder1_home_virtual;
    logic       encoder2_index_virtual;
    logic       encoder2_home_virtual;
  } ripsel_int_src_s;

  typedef struct packed {
    logic [NUM_PINS-1:0] pad_in;
    logic [NUM_PINS-1:0] analog_en;
  } ripsel_pads_s;

  typedef enum logic [1:0] {LK_LOCKED, LK_KEY1_SEEN, LK_OPEN} ripsel_lock_e;

  // valid selector codes; reserved codes select nothing
  function automatic logic sel_valid(input logic [SEL_W-1:0] sel);
    if (sel <= SRC_CMP_LAST) begin
      return 1'b1;
    end else if (sel >= SRC_ENC_FIRST && sel <= SRC_ENC_LAST) begin
      return 1'b1;
    end else if (sel >= SRC_PIN_FIRST) begin
      return PIN_PRESENT[sel];
    end else begin
      return 1'b0;
    end
  endfunction

endpackage

// >>> rtl/ripsel_lock.sv
// lock state machine guarding the input select registers
`timescale 1ns/100ps
module ripsel_lock
  import ripsel_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              lock_wr,
  input  wire logic [REG_W-1:0]  lock_wdata,
  output logic                   locked
);
  import ripsel_pkg::*;

  ripsel_lock_e state;

  // ==========================================================
  // unlock sequence: key1 then key2 on consecutive lock writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= LK_OPEN;
    end else if (lock_wr) begin
      case (state)
        LK_OPEN: begin
          if (lock_wdata == LOCK_KEY) state <= LK_LOCKED; // RULE_14
        end
        LK_LOCKED: begin
          if (lock_wdata == UNLOCK_KEY1) state <= LK_KEY1_SEEN;
        end
        LK_KEY1_SEEN: begin
          if (lock_wdata == UNLOCK_KEY2) state <= LK_OPEN; // RULE_14
          else state <= LK_LOCKED;
        end
        default: state <= LK_LOCKED;
      endcase
    end
  end

  always_comb begin
    locked = (state != LK_OPEN); // RULE_12
  end
endmodule

// >>> rtl/ripsel_route.sv
// one selector: source choice for one peripheral input
`timescale 1ns/100ps
module ripsel_route
  import ripsel_pkg::*;
(
  input  wire logic [SEL_W-1:0]    sel,
  input  wire ripsel_int_src_s     int_src,
  input  wire ripsel_pads_s        pads,
  output logic                     value
);
  import ripsel_pkg::*;

  always_comb begin
    value = 1'b0;
    if (!sel_valid(sel)) begin
      value = 1'b0; // RULE_08
    end else if (sel == SRC_TIE_LOW) begin
      value = 1'b0; // RULE_02
    end else if (sel <= SRC_CMP_LAST) begin
      value = int_src.comparator_output[sel[1:0] - 2'h1]; // RULE_08
    end else if (sel <= SRC_ENC_LAST) begin
      case (sel[1:0])
        2'h0:    value = int_src.encoder1_index_virtual;
        2'h1:    value = int_src.encoder1_home_virtual;
        2'h2:    value = int_src.encoder2_index_virtual;
        default: value = int_src.encoder2_home_virtual;
      endcase
    end else if (pads.analog_en[sel]) begin
      value = 1'b0; // RULE_04
    end else begin
      value = pads.pad_in[sel]; // RULE_07
    end
  end
endmodule

// >>> rtl/ripsel_top.sv
// remappable input pin select: register file and input crossbar
// ==========================================================
// Functional notes
// RULE_01: pins are either input-or-output remappable or input-only remappable, by number.
// RULE_02: a remapped input has no default pin and reads low until programmed.
// RULE_03: a remapped function on a pin wins over other digital functions on it.
// RULE_04: an enabled analog function on a pin is never overridden by a remap.
// RULE_05: inputs and outputs are mapped by separate register sets.
// RULE_06: each peripheral input owns a 7-bit selector in a 16-bit register.
// RULE_07: selector value n routes remappable pin n to the input.
// RULE_08: 0 is tie low, 1..3 comparators, 8..11 encoder signals, reserved selects nothing.
// RULE_09: all selectors reset to zero.
// RULE_10: bits 15 and 7 of each select register are unimplemented and read zero.
// RULE_11: the second encoder select register exists only on motor-control variants.
// RULE_12: hardware protection guards the mapping against spurious change.
// RULE_13: two-wire bus, PWM and analog modules are not routed by this crossbar.
// RULE_14: a lock bit blocks select writes until an unlock sequence clears it.
`timescale 1ns/100ps
module ripsel_top
  import ripsel_pkg::*;
#(
  parameter bit MOTOR_VARIANT = 1'b1
)
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [ADDR_W-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire ripsel_pads_s          pads,
  input  wire ripsel_int_src_s       int_src,
  input  wire logic [NUM_PINS-1:0]   other_digital_in,
  output logic [NUM_INPUTS-1:0]      periph_in,
  output logic [NUM_PINS-1:0]        pin_claimed,
  output logic [NUM_PINS-1:0]        other_digital_gated,
  output logic                       map_locked
);
  import ripsel_pkg::*;

  // ==========================================================
  // registers
  logic [SEL_W-1:0] sel [NUM_INPUTS];
  logic             ack;
  logic             locked;
  logic [NUM_INPUTS-1:0] next_periph_in;
  logic [NUM_PINS-1:0]   next_claimed;
  logic [15:0]           wdata16;
  logic [15:0]           rdata16;

  // ==========================================================
  // bus: one wait cycle, answer at second edge
  wire logic req = (avs_read || avs_write) && !ack;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  // registered twin of !ack so the port leaves a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !req;
    end
  end

  // byte lanes only for the low 16 bits
  always_comb begin
    wdata16[7:0]  = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    wdata16[15:8] = avs_byteenable[1] ? avs_writedata[15:8] : 8'h00;
  end

  wire logic wr_now = avs_write && ack;
  wire logic lock_wr = wr_now && (avs_address == OFS_LOCK_CTRL) && avs_byteenable[0];

  ripsel_lock u_lock (
    .clk        (clk),
    .resetn     (resetn),
    .lock_wr    (lock_wr),
    .lock_wdata (wdata16),
    .locked     (locked)
  );

  // ==========================================================
  // selector registers, input side only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        sel[i] <= SEL_RESET; // RULE_09
      end
    end else if (wr_now && !locked) begin // RULE_14
      if (avs_address == OFS_ENC2_SEL) begin
        if (MOTOR_VARIANT) begin // RULE_11
          if (avs_byteenable[0]) sel[IN_ENC2_INDEX] <= wdata16[LO_FIELD_LSB +: SEL_W]; // RULE_06
          if (avs_byteenable[1]) sel[IN_ENC2_HOME]  <= wdata16[HI_FIELD_LSB +: SEL_W];
        end
      end else if (avs_address == OFS_CAPT_SEL) begin
        if (avs_byteenable[0]) sel[IN_CAPT15] <= wdata16[LO_FIELD_LSB +: SEL_W];
        if (avs_byteenable[1]) sel[IN_CAPT16] <= wdata16[HI_FIELD_LSB +: SEL_W];
      end else if (avs_address == OFS_SYNC_SEL) begin
        if (avs_byteenable[0]) sel[IN_SYNC2] <= wdata16[LO_FIELD_LSB +: SEL_W];
        if (avs_byteenable[1]) sel[IN_SPARE] <= wdata16[HI_FIELD_LSB +: SEL_W];
      end
    end
  end

  // ==========================================================
  // read mux; unmapped reads zero
  always_comb begin
    rdata16 = REG_RESET;
    if (avs_address == OFS_ENC2_SEL) begin
      if (MOTOR_VARIANT) begin
        rdata16 = {1'b0, sel[IN_ENC2_HOME], 1'b0, sel[IN_ENC2_INDEX]}; // RULE_10
      end
    end else if (avs_address == OFS_CAPT_SEL) begin
      rdata16 = {1'b0, sel[IN_CAPT16], 1'b0, sel[IN_CAPT15]};
    end else if (avs_address == OFS_SYNC_SEL) begin
      rdata16 = {1'b0, sel[IN_SPARE], 1'b0, sel[IN_SYNC2]};
    end else if (avs_address == OFS_LOCK_CTRL) begin
      rdata16 = {15'h0000, locked};
    end
    rdata16 = (avs_address == OFS_LOCK_CTRL) ? rdata16 : (rdata16 & FIELD_MASK);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && req) begin
      avs_readdata <= {16'h0000, rdata16};
    end
  end

  // ==========================================================
  // crossbar: separate from any output mapping logic
  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : g_route
      ripsel_route u_route (
        .sel     (sel[g]),
        .int_src (int_src),
        .pads    (pads),
        .value   (next_periph_in[g])
      ); // RULE_05
    end
  endgenerate

  // pins claimed by a remap; other digital functions yield
  always_comb begin
    next_claimed = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (sel[i] >= SRC_PIN_FIRST && sel_valid(sel[i]) && !pads.analog_en[sel[i]]) begin
        next_claimed[sel[i]] = 1'b1; // RULE_01
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periph_in           <= '0;
      pin_claimed         <= '0;
      other_digital_gated <= '0;
      map_locked          <= 1'b0;
    end else begin
      periph_in           <= next_periph_in;
      pin_claimed         <= next_claimed;
      other_digital_gated <= other_digital_in & ~next_claimed & ~pads.analog_en; // RULE_03
      map_locked          <= locked;
    end
  end

  // two-wire bus, PWM and analog pins use dedicated paths outside this block
  // RULE_13
endmodule

// >>> test/ripsel_properties.sv
// checker: bus handshake, crossbar and lock properties
`timescale 1ns/100ps
module ripsel_chk
  import ripsel_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic [ADDR_W-1:0]     avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire ripsel_pads_s          pads,
  input wire logic [NUM_PINS-1:0]   other_digital_in,
  input wire logic [NUM_INPUTS-1:0] periph_in,
  input wire logic [NUM_PINS-1:0]   pin_claimed,
  input wire logic [NUM_PINS-1:0]   other_digital_gated,
  input wire logic                  map_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // bus
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_read_zero: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000 && !avs_readdata[15] && !avs_readdata[7])
    else $error("unimplemented read bits not zero");
  // ==========================================================
  // crossbar
  a_claim_analog: assert property ((pin_claimed & $past(pads.analog_en)) == '0)
    else $error("analog pin claimed by remap");
  a_gate_claim: assert property ((other_digital_gated & (pin_claimed | ~$past(other_digital_in)))
    == '0)
    else $error("digital function not gated by remap");
  a_reset_vals: assert property ($rose(resetn) |-> periph_in == '0 && !map_locked)
    else $error("outputs not cleared after reset");
  // ==========================================================
  // lock
  a_lock_rise: assert property ($rose(map_locked) |->
    $past(avs_write && avs_address == OFS_LOCK_CTRL, 2))
    else $error("lock set without lock write");
  a_lock_fall: assert property ($fell(map_locked) |->
    $past(avs_write && avs_address == OFS_LOCK_CTRL, 2))
    else $error("lock cleared without lock write");
  c_read_done: cover property (avs_read && !avs_waitrequest);
  c_locked: cover property ($rose(map_locked));
  c_claimed: cover property (|pin_claimed);
endmodule
bind ripsel_top ripsel_chk u_chk (.clk(clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pads(pads), .other_digital_in(other_digital_in),
  .periph_in(periph_in), .pin_claimed(pin_claimed),
  .other_digital_gated(other_digital_gated), .map_locked(map_locked));

// >>> test/ripsel_far.sv
// far side model: pads, comparator and encoder lines
`timescale 1ns/100ps
module ripsel_far
  import ripsel_pkg::*;
(
  input  wire logic                inv,
  input  wire logic [NUM_PINS-1:0] ana,
  output ripsel_pads_s             pads,
  output ripsel_int_src_s          int_src,
  output logic [NUM_PINS-1:0]      odi
);
  // ==========================================================
  // odd pins high, comparators 101, encoder lines 0110; inv flips all
  assign pads.pad_in    = {32{4'hA}} ^ {NUM_PINS{inv}};
  assign pads.analog_en = ana;
  assign int_src        = 7'h56 ^ {7{inv}};
  assign odi            = '1;
endmodule

// >>> test/tb_top.sv
// testbench: registers, routing table and lock of the input pin select
`timescale 1ns/100ps
module tb_top;
  import ripsel_pkg::*;
  logic                  clk, resetn, avs_read, avs_write, avs_waitrequest, map_locked, inv;
  logic [ADDR_W-1:0]     avs_address;
  logic [31:0]           avs_writedata, avs_readdata;
  logic [NUM_PINS-1:0]   ana, odi, claimed, gated, pexp;
  logic [NUM_INPUTS-1:0] periph_in;
  ripsel_pads_s          pads;
  ripsel_int_src_s       int_src;
  logic [15:0]           q;
  logic [6:0]            c;
  logic [6:0]            codes [19] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h09,
    7'h0A, 7'h0B, 7'h0C, 7'h11, 7'h18, 7'h1F, 7'h30, 7'h31, 7'h33, 7'h40, 7'h4F, 7'h7F};
  int                    mismatches, compares, cyc;
  ripsel_top DUT (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pads(pads),
    .int_src(int_src), .other_digital_in(odi), .periph_in(periph_in), .pin_claimed(claimed),
    .other_digital_gated(gated), .map_locked(map_locked));
  ripsel_far far (.inv(inv), .ana(ana), .pads(pads), .int_src(int_src), .odi(odi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic expv(input logic [6:0] s, input logic v);
    logic [127:0] pad;
    logic [2:0]   cm;
    logic [3:0]   en;
    pad = {32{4'hA}} ^ {128{v}};
    cm = 3'h5 ^ {3{v}};
    en = 4'h6 ^ {4{v}};
    if (s inside {[7'h01:7'h03]}) return cm[s-1];
    if (s inside {[7'h08:7'h0B]}) return en[s-8];
    if (s >= 7'h10 && PIN_PRESENT[s] && !ana[s]) return pad[s];
    return 1'b0;
  endfunction
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // ==========================================================
  // tests
  initial begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    inv = 1'b0;
    ana = 128'h1 << 49;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 4'(i * 4), 16'h0000);
      chk("reset reg", q, 16'h0000);
    end
    chk("idle inputs", periph_in, 6'h00);
    acc(1'b1, OFS_CAPT_SEL, 16'hFFFF);
    acc(1'b0, OFS_CAPT_SEL, 16'h0000);
    chk("field mask", q, 16'h7F7F);
    acc(1'b1, 4'h2, 16'hFFFF);
    acc(1'b0, 4'h2, 16'h0000);
    chk("unmapped", q, 16'h0000);
    $display("test registers done");
    foreach (codes[i]) begin
      c = codes[i];
      for (int r = 0; r < 3; r++) acc(1'b1, 4'(r * 4), {1'b0, c, 1'b0, c});
      pexp = (c >= 7'h10 && PIN_PRESENT[c] && !ana[c]) ? (128'h1 << c) : 128'h0;
      for (int v = 0; v < 2; v++) begin
        inv <= v[0];
        repeat (3) @(posedge clk);
        chk("route", periph_in, {6{expv(c, v[0])}});
        chk("claimed", claimed, pexp);
        chk("gated", gated, ~pexp & ~ana);
      end
    end
    $display("test routing done");
    acc(1'b1, OFS_LOCK_CTRL, 16'h0001);
    acc(1'b0, OFS_LOCK_CTRL, 16'h0000);
    chk("lock bit", q, 16'h0001);
    chk("lock out", map_locked, 1'b1);
    acc(1'b1, OFS_SYNC_SEL, 16'h0101);
    acc(1'b0, OFS_SYNC_SEL, 16'h0000);
    chk("blocked", q, 16'h7F7F);
    acc(1'b1, OFS_LOCK_CTRL, 16'h0046);
    acc(1'b1, OFS_LOCK_CTRL, 16'h0012);
    acc(1'b0, OFS_LOCK_CTRL, 16'h0000);
    chk("bad key", q, 16'h0001);
    acc(1'b1, OFS_LOCK_CTRL, 16'h0046);
    acc(1'b1, OFS_LOCK_CTRL, 16'h0057);
    acc(1'b0, OFS_LOCK_CTRL, 16'h0000);
    chk("unlock", q, 16'h0000);
    acc(1'b1, OFS_SYNC_SEL, 16'h0101);
    acc(1'b0, OFS_SYNC_SEL, 16'h0000);
    chk("open write", q, 16'h0101);
    repeat (3) @(posedge clk);
    chk("cmp route", periph_in[5:4], {2{expv(7'h01, inv)}});
    $display("test lock done");
    complete_run();
  end
endmodule
